// ### dv/shp_checker.sv
// port assertions for the host controller
`include "shp_defs.vh"
module shp_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic spi_sck,
	input wire logic [`SHP_NUM_SEL-1:0] spi_ss_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ********
	// link sequences
	// ********
	sequence sel_go;
		$fell(&spi_ss_n);
	endsequence
	sequence sck_turn;
		$changed(spi_sck) && !(&spi_ss_n);
	endsequence
	// both write halves taken at one edge; the answer is registered one edge later
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	wr_resp_a: assert property (wr_both |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");
	slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `SHP_RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("error read data");
	one_select_a: assert property ($onehot0(~spi_ss_n)) else $error("two selects");
	// idle level may only follow a control write, which answered one edge before
	sck_quiet_a: assert property ($changed(spi_sck) && (&spi_ss_n) && $past(&spi_ss_n)
		|-> $past(s_axi_bvalid)) else $error("clock without select");
	lead_gap_a: assert property (sel_go |-> $stable(spi_sck)[*4])
		else $error("clock before lead");
	bit_gap_a: assert property (sck_turn |=> $stable(spi_sck)[*3])
		else $error("clock too fast");
endmodule // shp_checker
bind shp_controller shp_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .spi_sck, .spi_ss_n);

// ### dv/shp_client_model.sv
// client-side device model facing the host controller
module shp_client_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] load,
	output logic miso,
	output logic [7:0] got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sr = 8'h00;
	logic b = 1'b0;
	initial miso = 1'b0;
	initial got = 8'h00;
	always @(negedge sel_n) begin
		sr = load;
		miso = load[7];
	end
	// released line shows the inverse so a stale bit cannot pass
	always @(posedge sel_n) begin
		got = sr;
		miso = ~miso;
	end
	always @(sck) begin
		if (!sel_n && (sck !== cpol)) begin
			if (cpha)
				miso = sr[7];
			else
				b = mosi;
		end
		else if (!sel_n) begin
			sr = {sr[6:0], cpha ? mosi : b};
			if (!cpha)
				miso = sr[7];
		end
	end
endmodule // shp_client_model

// ### dv/shp_controller_bench.sv
// bench for the host controller: register tasks and link exchanges
`include "shp_defs.vh"
module shp_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, load = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, cpol = 1'b0, cpha = 1'b0;
	logic [1:0] sel = 2'h0, resp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire spi_sck, spi_mosi, spi_miso;
	wire [3:0] spi_ss_n;
	wire [7:0] got;
	int mismatches = 0, samples_checked = 0, tn = 0;
	shp_controller u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .spi_sck, .spi_mosi, .spi_miso, .spi_ss_n);
	shp_client_model u_cli (.sck(spi_sck), .mosi(spi_mosi), .sel_n(spi_ss_n[sel]), .cpol(cpol),
		.cpha(cpha), .load(load), .miso(spi_miso), .got(got));
	initial forever #4 aclk = ~aclk;
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		conclude;
	end
	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s exp %h seen %h", n, e, s);
		end
	endtask
	task end_test;
		tn++;
		$display("test %0d done", tn);
	endtask
	// ********
	// register access
	// ********
	task wr(logic [7:0] a, logic [31:0] v);
		bit ak, wk;
		ak = 0;
		wk = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ak && wk)) begin
			@(posedge aclk);
			if (s_axi_awready) begin
				ak = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready) begin
				wk = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
	endtask
	task rd(logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task xf(logic [7:0] h, logic [7:0] c);
		load <= c;
		wr(`SHP_OFF_TX, {24'h0, h});
		do rd(`SHP_OFF_STAT); while (d[0]);
	endtask
	task cfg(logic [1:0] m, logic k);
		wr(`SHP_OFF_CTRL, 32'h0);
		sel <= m;
		cpol <= m[0];
		cpha <= m[1];
		wr(`SHP_OFF_CTRL, {25'h0, k, m, 1'b0, m, 1'b1});
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SHP_OFF_CTRL);
		chk("ctrl", d, 32'h0);
		rd(`SHP_OFF_DIV);
		chk("div", d, 32'h10);
		rd(`SHP_OFF_STAT);
		chk("stat", d, 32'h0);
		wr(8'h14, 32'h5);
		chk("bresp", resp, 2'h2);
		rd(8'h14);
		chk("rresp", resp, 2'h2);
		wr(`SHP_OFF_DIV, 32'h8);
		rd(`SHP_OFF_DIV);
		chk("div", d, 32'h8);
		end_test;
		for (int m = 0; m < 4; m++) begin
			cfg(m[1:0], 1'b0);
			xf(8'hA5 ^ m[7:0], 8'h3C + m[7:0]);
			rd(`SHP_OFF_STAT);
			chk("stat", d, 32'h12);
			rd(`SHP_OFF_RX);
			chk("rx", d, 8'h3C + m[7:0]);
			chk("got", got, 8'hA5 ^ m[7:0]);
			chk("sck", spi_sck, m[0]);
			rd(`SHP_OFF_STAT);
			chk("stat", d, 32'h10);
		end
		end_test;
		load <= 8'h5A;
		wr(`SHP_OFF_TX, 32'h81);
		wr(`SHP_OFF_TX, 32'h7E);
		rd(`SHP_OFF_STAT);
		chk("coll", d[2], 1'b1);
		do rd(`SHP_OFF_STAT); while (d[0]);
		rd(`SHP_OFF_RX);
		chk("rx", d, 32'h5A);
		chk("got", got, 8'h81);
		rd(`SHP_OFF_STAT);
		chk("stat", d, 32'h14);
		wr(`SHP_OFF_TX, 32'h11);
		rd(`SHP_OFF_STAT);
		chk("stat", d, 32'h14);
		wr(`SHP_OFF_STAT, 32'h4);
		xf(8'hC3, 8'h99);
		chk("got", got, 8'hC3);
		end_test;
		xf(8'h0F, 8'hF0);
		rd(`SHP_OFF_STAT);
		chk("ovr", d, 32'h1A);
		rd(`SHP_OFF_RX);
		chk("rx", d, 32'hF0);
		wr(`SHP_OFF_STAT, 32'h8);
		wr(`SHP_OFF_TX, 32'h55);
		wr(`SHP_OFF_CTRL, 32'h0);
		@(posedge aclk);
		chk("ss", spi_ss_n, 4'hF);
		rd(`SHP_OFF_STAT);
		chk("stat", d, 32'h0);
		end_test;
		cfg(2'h1, 1'b1);
		xf(8'h24, 8'h42);
		chk("ss", spi_ss_n, 4'hD);
		wr(`SHP_OFF_CTRL, 32'h13);
		@(posedge aclk);
		chk("ss", spi_ss_n, 4'hF);
		chk("got", got, 8'h24);
		end_test;
		conclude;
	end
endmodule // shp_controller_bench

// ### rtl/shp_controller.v
// serial port host controller: AXI4-Lite registers and the SPI host engine
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`include "shp_defs.vh"

module shp_controller (
	input wire aclk,
	input wire aresetn,
	input wire [`SHP_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`SHP_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg spi_sck,
	output reg spi_mosi,
	input wire spi_miso,
	output reg [`SHP_NUM_SEL-1:0] spi_ss_n
);
	// ********************************************************************
	// state and registers
	// ********************************************************************
	reg [`SHP_ADDR_W-1:0] waddr;
	reg [31:0] wdata;
	reg [3:0] wstrb;
	reg enable;
	reg cpol;
	reg cpha;
	reg keep_sel;
	reg [1:0] sel;
	reg [15:0] div;
	reg [3:0] state;
	reg [15:0] cnt;
	reg [3:0] edge_cnt;
	reg [7:0] sr;
	reg sbit;
	reg [7:0] rx_data;
	reg rx_valid;
	reg collision;
	reg overrun;
	reg rx_set;

	localparam [3:0] ST_IDLE = `SHP_ST_IDLE;
	localparam [3:0] ST_LEAD = `SHP_ST_LEAD;
	localparam [3:0] ST_RUN = `SHP_ST_RUN;
	localparam [3:0] ST_TAIL = `SHP_ST_TAIL;

	wire miso_s;
	wire busy = (state != ST_IDLE);
	wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_ctrl = do_write && (waddr == `SHP_OFF_CTRL);
	wire wr_div = do_write && (waddr == `SHP_OFF_DIV);
	wire wr_tx = do_write && (waddr == `SHP_OFF_TX) && wstrb[0];
	wire wr_stat = do_write && (waddr == `SHP_OFF_STAT) && wstrb[0];
	wire wr_ok = (waddr == `SHP_OFF_CTRL) || (waddr == `SHP_OFF_DIV) ||
		(waddr == `SHP_OFF_TX) || (waddr == `SHP_OFF_RX) || (waddr == `SHP_OFF_STAT);
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_rx = rd_take && (s_axi_araddr == `SHP_OFF_RX);
	// a collision blocks every following transmit write until cleared
	wire coll_set = wr_tx && (busy || collision);
	wire tx_go = wr_tx && enable && !busy && !collision;
	// the pin synchroniser costs four clocks, so the half period has a floor
	wire [15:0] half_len = (div < `SHP_HALF_MIN) ? `SHP_HALF_MIN : div;
	wire tick = (cnt == half_len - 16'h0001);
	wire lead = !edge_cnt[0];
	wire sample_now = lead ^ cpha;
	wire [`SHP_NUM_SEL-1:0] sel_mask = ~(4'h1 << sel);

	shp_sync3 u_miso_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(spi_miso),
		.dout(miso_s)
	);

	// ********************************************************************
	// AXI4-Lite write channels
	// ********************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SHP_RESP_OKAY;
			waddr <= {`SHP_ADDR_W{1'b0}};
			wdata <= 32'h00000000;
			wstrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata <= s_axi_wdata;
				wstrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SHP_RESP_OKAY : `SHP_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ********************************************************************
	// AXI4-Lite read channels
	// ********************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SHP_RESP_OKAY;
		end else begin
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SHP_RESP_OKAY;
				case (s_axi_araddr)
					`SHP_OFF_CTRL: begin
						s_axi_rdata <= {25'h0000000, keep_sel, sel, 1'b0, cpha, cpol, enable};
					end
					`SHP_OFF_DIV: begin
						s_axi_rdata <= {16'h0000, div};
					end
					`SHP_OFF_TX: begin
						s_axi_rdata <= 32'h00000000;
					end
					`SHP_OFF_RX: begin
						s_axi_rdata <= {24'h000000, rx_data};
					end
					`SHP_OFF_STAT: begin
						s_axi_rdata <= {27'h0000000, enable, overrun, collision, rx_valid, busy};
					end
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `SHP_RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ********************************************************************
	// configuration and sticky flags
	// ********************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			enable <= 1'b0;
			cpol <= 1'b0;
			cpha <= 1'b0;
			keep_sel <= 1'b0;
			sel <= 2'h0;
			div <= `SHP_DIV_RESET;
			rx_valid <= 1'b0;
			collision <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (wr_ctrl && wstrb[0]) begin
				enable <= wdata[`SHP_CTRL_EN];
				keep_sel <= wdata[`SHP_CTRL_KEEP];
				// shape of the link stays frozen while the port runs
				if (!enable) begin
					cpol <= wdata[`SHP_CTRL_CPOL];
					cpha <= wdata[`SHP_CTRL_CPHA];
					sel <= wdata[`SHP_CTRL_SEL_HI:`SHP_CTRL_SEL_LO];
				end
			end
			if (wr_div && !enable) begin
				if (wstrb[0]) begin
					div[7:0] <= wdata[7:0];
				end
				if (wstrb[1]) begin
					div[15:8] <= wdata[15:8];
				end
			end
			// hardware set wins over software clear on every flag
			if (rx_set) begin
				rx_valid <= 1'b1;
			end else if (rd_rx) begin
				rx_valid <= 1'b0;
			end
			if (coll_set) begin
				collision <= 1'b1;
			end else if (wr_stat && wdata[`SHP_STAT_COLL]) begin
				collision <= 1'b0;
			end
			// unread byte overwritten: software skipped the read before the next write
			if (rx_set && rx_valid && !rd_rx) begin
				overrun <= 1'b1;
			end else if (wr_stat && wdata[`SHP_STAT_OVR]) begin
				overrun <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// SPI host engine
	// ********************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 16'h0000;
			edge_cnt <= 4'h0;
			sr <= 8'h00;
			sbit <= 1'b0;
			rx_data <= 8'h00;
			rx_set <= 1'b0;
			spi_sck <= 1'b0;
			spi_mosi <= 1'b0;
			spi_ss_n <= {`SHP_NUM_SEL{1'b1}};
		end else begin
			rx_set <= 1'b0;
			cnt <= tick ? 16'h0000 : cnt + 16'h0001;
			case (state)
				ST_IDLE: begin
					cnt <= 16'h0000;
					edge_cnt <= 4'h0;
					spi_sck <= cpol;
					if (tx_go) begin
						sr <= wdata[7:0];
						spi_mosi <= wdata[7];
						spi_ss_n <= sel_mask;
						state <= ST_LEAD;
					end else if (!keep_sel) begin
						spi_ss_n <= {`SHP_NUM_SEL{1'b1}};
					end
				end
				ST_LEAD: begin
					if (tick) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (tick) begin
						spi_sck <= ~spi_sck;
						edge_cnt <= edge_cnt + 4'h1;
						if (sample_now) begin
							sbit <= miso_s;
							if (edge_cnt == `SHP_LAST_EDGE) begin
								sr <= {sr[6:0], miso_s};
							end
						end else if (cpha && edge_cnt == 4'h0) begin
							spi_mosi <= sr[7];
						end else begin
							sr <= {sr[6:0], sbit};
							spi_mosi <= sr[6];
						end
						if (edge_cnt == `SHP_LAST_EDGE) begin
							state <= ST_TAIL;
						end
					end
				end
				ST_TAIL: begin
					if (tick) begin
						rx_data <= sr;
						rx_set <= 1'b1;
						state <= ST_IDLE;
						if (!keep_sel) begin
							spi_ss_n <= {`SHP_NUM_SEL{1'b1}};
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			// disabling aborts a byte and releases the bus
			if (!enable) begin
				state <= ST_IDLE;
				spi_sck <= cpol;
				spi_ss_n <= {`SHP_NUM_SEL{1'b1}};
			end
		end
	end
endmodule // shp_controller

// ### rtl/shp_defs.vh
// constants for the serial port host controller: register map, fields, timing
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH

// ********************************************************************
// bus geometry
// ********************************************************************
`define SHP_ADDR_W 8
`define SHP_RESP_OKAY 2'h0
`define SHP_RESP_SLVERR 2'h2

// ********************************************************************
// register offsets (byte addresses, one aligned word each)
// ********************************************************************
`define SHP_OFF_CTRL 8'h00
`define SHP_OFF_DIV 8'h04
`define SHP_OFF_TX 8'h08
`define SHP_OFF_RX 8'h0C
`define SHP_OFF_STAT 8'h10

// ********************************************************************
// control register fields
// ********************************************************************
`define SHP_CTRL_EN 0
`define SHP_CTRL_CPOL 1
`define SHP_CTRL_CPHA 2
`define SHP_CTRL_SEL_LO 4
`define SHP_CTRL_SEL_HI 5
`define SHP_CTRL_KEEP 6
`define SHP_CTRL_RESET 32'h00000000
`define SHP_DIV_RESET 16'h0010

// ********************************************************************
// status register fields
// ********************************************************************
`define SHP_STAT_BUSY 0
`define SHP_STAT_RXV 1
`define SHP_STAT_COLL 2
`define SHP_STAT_OVR 3
`define SHP_STAT_EN 4

// ********************************************************************
// link shape and timing
// ********************************************************************
`define SHP_NUM_SEL 4
`define SHP_LAST_EDGE 4'hF
`define SHP_CLK_PERIOD_NS 8
`define SHP_HALF_MIN 16'h0004

// ********************************************************************
// controller states, one-hot
// ********************************************************************
`define SHP_ST_IDLE 4'h1
`define SHP_ST_LEAD 4'h2
`define SHP_ST_RUN 4'h4
`define SHP_ST_TAIL 4'h8

`endif

// ### rtl/shp_sync3.v
// three-stage input synchroniser that passes a change once stages two and three agree
module shp_sync3 (
	input wire aclk,
	input wire aresetn,
	input wire din,
	output reg dout
);
	reg s1;
	reg s2;
	reg s3;

	// ********************************************************************
	// stage one feeds stage two only
	// ********************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule // shp_sync3
